// file: rtl/esi_interlock.sv
// emergency stop interlock: power-up sequencing and stop path
//
// Contract
// - stop input is logic controller input one
// - stop loss: fault, enables off, velocities zero
// - stop output low throughout initialization
// - init success sets stop output bit to 1
// - init failure keeps output low, shows error
// - run stored program, else wait for one
// - after first scan, output follows logic bit
// - internal error raises alarm, output low
// - program may drive stop output low
`default_nettype none
module esi_interlock
  import esi_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // cabinet side
  input wire logic i_estop_in,
  output logic o_estop_out_n,
  // initialization sequencer
  input wire logic i_init_done,
  input wire logic i_init_fail,
  input wire logic [ESI_ERR_W-1:0] i_init_err_code,
  // internal error detection
  input wire logic i_internal_err,
  // logic controller program
  input wire logic i_prog_loaded,
  input wire logic i_scan_done,
  input wire logic i_bit_wr,
  input wire logic i_bit_wdata,
  output logic o_estop_plc_input,
  output logic o_estop_plc_output_bit,
  output logic o_plc_run,
  output logic o_first_scan_routine,
  output logic o_alarm_n,
  // axes
  input wire logic [ESI_AXES-1:0] i_axis_en,
  input wire logic [ESI_AXES*ESI_VEL_W-1:0] i_vel_cmd,
  output logic [ESI_AXES-1:0] o_axis_en,
  output logic [ESI_AXES*ESI_VEL_W-1:0] o_vel_cmd,
  // status
  output logic o_ext_stop_fault,
  output logic [ESI_ERR_W-1:0] o_err_code
);

  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  esi_sync_if sif ();
  assign sif.raw = i_estop_in;
  esi_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .sif(sif)
  );
  logic estop_ok;
  assign estop_ok = sif.synced;

  // ----------------------------------------
  // synchroniser fill tracking
  // ----------------------------------------
  // the second stage holds its reset level until the second edge after release;
  // no stop fault is reported from that stale level
  logic [1:0] fill;
  logic sync_full;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      fill <= 2'h0;
    end else begin
      fill <= {fill[0], 1'h1};
    end
  end

  assign sync_full = fill[1];

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  esi_state_t state;
  esi_state_t next_state;
  logic alarm;

  always_comb begin
    next_state = state;
    unique case (state)
      ESI_ST_INIT: begin
        if (i_init_fail) begin
          next_state = ESI_ST_FAIL;
        end else if (i_init_done) begin
          next_state = ESI_ST_WAIT_PROG;
        end
      end
      ESI_ST_FAIL: begin
        next_state = ESI_ST_FAIL;
      end
      ESI_ST_WAIT_PROG: begin
        if (i_prog_loaded) begin
          next_state = ESI_ST_FIRST_SCAN;
        end
      end
      ESI_ST_FIRST_SCAN: begin
        if (i_scan_done) begin
          next_state = ESI_ST_RUN;
        end
      end
      ESI_ST_RUN: begin
        next_state = ESI_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      state <= ESI_ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // stop output logic bit
  // ----------------------------------------
  logic out_bit;
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      out_bit <= ESI_BIT_RST;
    end else if (state == ESI_ST_INIT && i_init_done && !i_init_fail) begin
      out_bit <= 1'b1;
    end else if (i_bit_wr && (state == ESI_ST_FIRST_SCAN ||
                              state == ESI_ST_RUN)) begin
      out_bit <= i_bit_wdata;
    end
  end

  // ----------------------------------------
  // alarm and error reporting
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      alarm <= 1'b0;
    end else if (i_internal_err) begin
      alarm <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_err_code <= ESI_ERR_NONE;
    end else if (state == ESI_ST_INIT && i_init_fail) begin
      o_err_code <= (i_init_err_code == ESI_ERR_NONE) ? ESI_ERR_INIT
                                                       : i_init_err_code;
    end else if (i_internal_err) begin
      o_err_code <= ESI_ERR_INTERNAL;
    end else if (sync_full && !estop_ok && o_err_code == ESI_ERR_NONE &&
                 state != ESI_ST_INIT) begin
      o_err_code <= ESI_ERR_EXT_STOP;
    end
  end

  // ----------------------------------------
  // physical outputs
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_estop_out_n <= 1'b0;
    end else if (alarm || i_internal_err) begin
      o_estop_out_n <= 1'b0;
    end else if (state == ESI_ST_RUN) begin
      o_estop_out_n <= out_bit;
    end else begin
      o_estop_out_n <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_estop_plc_input <= 1'b0;
    end else begin
      o_estop_plc_input <= estop_ok;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_ext_stop_fault <= 1'b0;
    end else begin
      o_ext_stop_fault <= sync_full && !estop_ok;
    end
  end

  // ----------------------------------------
  // per-axis gating
  // ----------------------------------------
  wire logic [ESI_AXES-1:0] gated_en;
  wire logic [ESI_AXES*ESI_VEL_W-1:0] gated_vel;

  for (genvar ax = 0; ax < ESI_AXES; ax++) begin : g_axis
    assign gated_en[ax] = estop_ok && i_axis_en[ax];
    assign gated_vel[ax*ESI_VEL_W +: ESI_VEL_W] =
      estop_ok ? i_vel_cmd[ax*ESI_VEL_W +: ESI_VEL_W] : '0;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_axis_en <= '0;
      o_vel_cmd <= '0;
    end else begin
      o_axis_en <= gated_en;
      o_vel_cmd <= gated_vel;
    end
  end

  assign o_estop_plc_output_bit = out_bit;
  assign o_plc_run = (state == ESI_ST_FIRST_SCAN) || (state == ESI_ST_RUN);
  assign o_first_scan_routine = (state == ESI_ST_FIRST_SCAN);
  assign o_alarm_n = !alarm;

endmodule
`default_nettype wire

// file: rtl/esi_pkg.sv
// constants and types shared by the stop interlock design
`default_nettype none
package esi_pkg;
  localparam int unsigned ESI_AXES = 4;
  localparam int unsigned ESI_VEL_W = 16;
  localparam int unsigned ESI_ERR_W = 4;
  localparam logic [ESI_ERR_W-1:0] ESI_ERR_NONE = 4'h0;
  localparam logic [ESI_ERR_W-1:0] ESI_ERR_INIT = 4'h1;
  localparam logic [ESI_ERR_W-1:0] ESI_ERR_INTERNAL = 4'h2;
  localparam logic [ESI_ERR_W-1:0] ESI_ERR_EXT_STOP = 4'h3;
  localparam logic ESI_SYNC_RST = 1'b0;
  localparam logic ESI_BIT_RST = 1'b0;
  typedef enum logic [2:0] {
    ESI_ST_INIT,
    ESI_ST_FAIL,
    ESI_ST_WAIT_PROG,
    ESI_ST_FIRST_SCAN,
    ESI_ST_RUN
  } esi_state_t;
endpackage
`default_nettype wire

// file: rtl/esi_sync_if.sv
// interface carrying the stop input synchroniser signals
`default_nettype none
interface esi_sync_if;
  logic raw;
  logic synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface
`default_nettype wire

// file: rtl/esi_sync.sv
// two-stage synchroniser for the external stop input
`default_nettype none
module esi_sync
  import esi_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // signals
  esi_sync_if.snk sif
);
  logic stage1;
  logic stage2;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      stage1 <= ESI_SYNC_RST;
      stage2 <= ESI_SYNC_RST;
    end else begin
      stage1 <= sif.raw;
      stage2 <= stage1;
    end
  end

  assign sif.synced = stage2;
endmodule
`default_nettype wire

// file: testbench/esi_cab.sv
// cabinet side model driving the external stop loop
`default_nettype none
module esi_cab (
  // stop request from the bench
  input wire logic i_drop,
  // stop loop level toward the controller
  output logic o_estop_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // loop stays at its active level unless a stop is requested
  assign o_estop_in = !i_drop;
endmodule
`default_nettype wire

// file: testbench/esi_assertions.sv
// assertions watching the stop interlock ports
`default_nettype none
module esi_chk
  import esi_pkg::*;
(
  // clock, reset and inputs
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_estop_in,
  input wire logic i_init_done,
  input wire logic i_init_fail,
  input wire logic i_internal_err,
  input wire logic i_prog_loaded,
  // outputs
  input wire logic o_estop_out_n,
  input wire logic o_estop_plc_output_bit,
  input wire logic o_plc_run,
  input wire logic o_first_scan_routine,
  input wire logic o_alarm_n,
  input wire logic o_ext_stop_fault,
  input wire logic [ESI_AXES-1:0] o_axis_en,
  input wire logic [ESI_AXES*ESI_VEL_W-1:0] o_vel_cmd,
  input wire logic [ESI_ERR_W-1:0] o_err_code
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_lost; !i_estop_in [*3]; endsequence
  sequence s_drop; i_estop_in [*3] ##1 !i_estop_in; endsequence
  property p_stop; s_lost |=> o_ext_stop_fault && !o_axis_en && !o_vel_cmd;
  endproperty
  property p_sync; s_drop |=> !o_ext_stop_fault [*2]; endproperty
  property p_low; o_estop_out_n |-> $past(o_plc_run); endproperty
  property p_done; i_init_done && !i_init_fail && !o_err_code && !o_plc_run
    |=> o_estop_plc_output_bit; endproperty
  property p_fail; i_init_fail && !o_plc_run && !o_estop_plc_output_bit &&
    !o_err_code |=> o_err_code && !o_estop_out_n; endproperty
  property p_alarm; i_internal_err |=> (!o_alarm_n && !o_estop_out_n) [*3];
  endproperty
  property p_follow; o_plc_run && !o_first_scan_routine && o_alarm_n &&
    !i_internal_err |=> o_estop_out_n == $past(o_estop_plc_output_bit);
  endproperty
  property p_wait; o_estop_plc_output_bit && !o_plc_run
    |=> o_plc_run == $past(i_prog_loaded); endproperty
  a_stop: assert property (p_stop) else $error("stop");
  a_sync: assert property (p_sync) else $error("sync");
  a_low: assert property (p_low) else $error("early");
  a_done: assert property (p_done) else $error("done");
  a_fail: assert property (p_fail) else $error("fail");
  a_alarm: assert property (p_alarm) else $error("alarm");
  a_follow: assert property (p_follow) else $error("follow");
  a_wait: assert property (p_wait) else $error("wait");
endmodule
bind esi_interlock esi_chk u_chk (
  .i_core_clk(i_core_clk),
  .i_resetn(i_resetn),
  .i_estop_in(i_estop_in),
  .i_init_done(i_init_done),
  .i_init_fail(i_init_fail),
  .i_internal_err(i_internal_err),
  .i_prog_loaded(i_prog_loaded),
  .o_estop_out_n(o_estop_out_n),
  .o_estop_plc_output_bit(o_estop_plc_output_bit),
  .o_plc_run(o_plc_run),
  .o_first_scan_routine(o_first_scan_routine),
  .o_alarm_n(o_alarm_n),
  .o_ext_stop_fault(o_ext_stop_fault),
  .o_axis_en(o_axis_en),
  .o_vel_cmd(o_vel_cmd),
  .o_err_code(o_err_code)
);
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the stop interlock
`default_nettype none
module tb
  import esi_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk = 0, i_resetn = 0, i_init_done = 0, i_init_fail = 0;
  logic i_internal_err = 0, i_prog_loaded = 0, i_scan_done = 0;
  logic i_bit_wr = 0, i_bit_wdata = 0, drop = 0, i_estop_in;
  logic [ESI_ERR_W-1:0] i_init_err_code = 4'h5, o_err_code;
  logic [ESI_AXES-1:0] i_axis_en = 4'hF, o_axis_en;
  logic [ESI_AXES*ESI_VEL_W-1:0] i_vel_cmd = {4{16'h1234}}, o_vel_cmd;
  logic o_estop_out_n, o_estop_plc_input, o_estop_plc_output_bit;
  logic o_plc_run, o_first_scan_routine, o_alarm_n, o_ext_stop_fault;
  int err_total = 0, n_checks = 0, cyc = 0;
  always #12.5 i_core_clk = ~i_core_clk;
  esi_interlock uut (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_estop_in(i_estop_in),
    .o_estop_out_n(o_estop_out_n),
    .i_init_done(i_init_done),
    .i_init_fail(i_init_fail),
    .i_init_err_code(i_init_err_code),
    .i_internal_err(i_internal_err),
    .i_prog_loaded(i_prog_loaded),
    .i_scan_done(i_scan_done),
    .i_bit_wr(i_bit_wr),
    .i_bit_wdata(i_bit_wdata),
    .o_estop_plc_input(o_estop_plc_input),
    .o_estop_plc_output_bit(o_estop_plc_output_bit),
    .o_plc_run(o_plc_run),
    .o_first_scan_routine(o_first_scan_routine),
    .o_alarm_n(o_alarm_n),
    .i_axis_en(i_axis_en),
    .i_vel_cmd(i_vel_cmd),
    .o_axis_en(o_axis_en),
    .o_vel_cmd(o_vel_cmd),
    .o_ext_stop_fault(o_ext_stop_fault),
    .o_err_code(o_err_code)
  );
  esi_cab cab (.i_drop(drop), .o_estop_in(i_estop_in));
  task chk(input logic [79:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task conclude;
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task tk(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task rst;
    tk(1);
    i_resetn <= 0;
    tk(2);
    i_resetn <= 1;
  endtask
  task wr(input logic v);
    tk(1);
    i_bit_wr <= 1;
    i_bit_wdata <= v;
    tk(1);
    i_bit_wr <= 0;
    tk(2);
    #1;
  endtask
  task t_boot;
    rst();
    i_init_done <= 1'h1;
    tk(1);
    i_init_done <= 1'h0;
    #1 chk({o_estop_plc_output_bit, o_estop_out_n}, 2'h2);
    wr(1'h0);
    chk({o_estop_plc_output_bit, o_plc_run}, 2'h2);
    chk({o_ext_stop_fault, o_err_code}, 5'h00);
    tk(1);
    i_prog_loaded <= 1'h1;
    wr(1'h0);
    chk({o_first_scan_routine, o_estop_plc_output_bit}, 2'h2);
    wr(1'h1);
    chk(o_estop_out_n, 1'h0);
    tk(1);
    i_scan_done <= 1'h1;
    tk(1);
    i_scan_done <= 1'h0;
    tk(2);
    #1 chk(o_estop_out_n, 1'h1);
    wr(1'h0);
    chk(o_estop_out_n, 1'h0);
    wr(1'h1);
    chk(o_estop_out_n, 1'h1);
    tk(1);
    i_internal_err <= 1'h1;
    tk(1);
    i_internal_err <= 1'h0;
    tk(1);
    #1 chk({o_alarm_n, o_estop_out_n, o_err_code}, 6'h02);
  endtask
  task t_fail;
    rst();
    i_init_fail <= 1'h1;
    tk(1);
    i_init_fail <= 1'h0;
    i_init_done <= 1'h1;
    tk(2);
    i_init_done <= 1'h0;
    #1 chk({o_estop_out_n, o_estop_plc_output_bit, !o_err_code}, 3'h0);
    chk(o_err_code, 4'h5);
    rst();
    i_init_err_code <= 4'h0;
    i_init_fail <= 1'h1;
    tk(1);
    i_init_fail <= 1'h0;
    #1 chk({o_estop_out_n, o_err_code}, {1'h0, ESI_ERR_INIT});
  endtask
  task t_stop;
    rst();
    i_init_done <= 1'h1;
    tk(1);
    i_init_done <= 1'h0;
    tk(2);
    drop <= 1'h1;
    tk(5);
    #1 chk({o_ext_stop_fault, o_estop_plc_input, o_err_code, o_axis_en,
      o_vel_cmd}, {2'h2, 4'h3, 68'h0});
    tk(1);
    drop <= 1'h0;
    tk(5);
    #1 chk({o_ext_stop_fault, o_estop_plc_input, o_axis_en, o_vel_cmd},
      {2'h1, 4'hF, i_vel_cmd});
    chk(o_err_code, ESI_ERR_EXT_STOP);
  endtask
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    t_boot();
    t_fail();
    t_stop();
    conclude();
  end
endmodule
`default_nettype wire
